// *** core/umpc_defines.vh ***
// Constants for the two-port serial pin control block
`ifndef UMPC_DEFINES_VH
`define UMPC_DEFINES_VH
`define UMPC_LINE_MARK 1'b1
`define UMPC_READY_OFF_N 1'b1
`define UMPC_CLK_HZ 200000000
`define UMPC_BAUD_DEFAULT 115200
`define UMPC_FIFO_DEPTH 16
`define UMPC_DATA_BITS 8
`endif

// *** core/umpc_fifo.v ***
// Synchronous FIFO with valid/ready on both sides
`default_nettype none
module umpc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire ref_clk,
   input wire rst,
   input wire in_valid,
   output wire in_ready,
   input wire [WIDTH-1:0] in_data,
   output wire out_valid,
   input wire out_ready,
   output wire [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire do_wr;
   wire do_rd;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   always @(posedge ref_clk) begin
      if (do_wr) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (do_wr) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
         end
         if (do_rd) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count <= count + 1'b1;
         end else if (do_rd && !do_wr) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** core/umpc_top.v ***
// Two serial ports: transmit path with FIFO, pin synchronisers and handshake pins
`include "umpc_defines.vh"
`default_nettype none
// How it works
// RL1 - On reset each serial output idles high until a frame starts.
// RL2 - Far modem pulls clear-to-send low when ready, high when not.
// RL3 - Clear-to-send level is readable as a modem status output.
// RL4 - Request-to-send is driven low when the port is ready to exchange data.
// RL5 - Reset forces request-to-send high.
// RL6 - Loopback mode holds request-to-send high regardless of software.
// RL7 - Two independent ports: fast port and console port.
// RL8 - Clear-to-send and serial inputs pass two flip-flops before use.
module umpc_top #(
   parameter BAUD_DIV_FAST = 16'h06C8,
   parameter BAUD_DIV_CONSOLE = 16'h06C8
) (
   input wire ref_clk,
   input wire rst,
   input wire fast_port_serial_in,
   output wire fast_port_serial_out,
   input wire fast_port_peer_ready_n,
   output wire fast_port_local_ready_n,
   input wire fast_tx_valid,
   output wire fast_tx_ready,
   input wire [7:0] fast_tx_data,
   input wire fast_rts_request,
   input wire fast_loopback,
   input wire fast_cts_flow,
   output wire fast_peer_ready,
   output wire fast_rx_level,
   input wire console_port_serial_in,
   output wire console_port_serial_out,
   input wire console_port_peer_ready_n,
   output wire console_port_local_ready_n,
   input wire console_tx_valid,
   output wire console_tx_ready,
   input wire [7:0] console_tx_data,
   input wire console_rts_request,
   input wire console_loopback,
   input wire console_cts_flow,
   output wire console_peer_ready,
   output wire console_rx_level
);
   wire [1:0] serial_in_pin;
   wire [1:0] peer_n_pin;
   wire [1:0] tx_valid;
   wire [1:0] tx_ready;
   wire [15:0] tx_data;
   wire [1:0] rts_request;
   wire [1:0] loopback;
   wire [1:0] cts_flow;
   wire [1:0] serial_out;
   wire [1:0] local_ready_n;
   wire [1:0] peer_ready;
   wire [1:0] rx_level;
   wire [31:0] baud_div;

   assign serial_in_pin = {console_port_serial_in, fast_port_serial_in};
   assign peer_n_pin = {console_port_peer_ready_n, fast_port_peer_ready_n};
   assign tx_valid = {console_tx_valid, fast_tx_valid};
   assign tx_data = {console_tx_data, fast_tx_data};
   assign rts_request = {console_rts_request, fast_rts_request};
   assign loopback = {console_loopback, fast_loopback};
   assign cts_flow = {console_cts_flow, fast_cts_flow};
   assign baud_div = {BAUD_DIV_CONSOLE[15:0], BAUD_DIV_FAST[15:0]};
   assign fast_port_serial_out = serial_out[0];
   assign console_port_serial_out = serial_out[1];
   assign fast_port_local_ready_n = local_ready_n[0];
   assign console_port_local_ready_n = local_ready_n[1];
   assign fast_tx_ready = tx_ready[0];
   assign console_tx_ready = tx_ready[1];
   assign fast_peer_ready = peer_ready[0];
   assign console_peer_ready = peer_ready[1];
   assign fast_rx_level = rx_level[0];
   assign console_rx_level = rx_level[1];

   genvar p;
   generate
      for (p = 0; p < 2; p = p + 1) begin : port // RL7
         reg [1:0] sin_sync;
         reg [1:0] cts_sync;
         reg rts_n;
         reg txd;
         reg [15:0] baud_cnt;
         reg baud_tick;
         reg [3:0] bit_cnt;
         reg [8:0] shifter;
         reg busy;
         wire f_valid;
         wire f_ready;
         wire [7:0] f_data;
         wire peer_ok;

         // Pins are asynchronous to ref_clk
         always @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               sin_sync <= 2'b11; // RL8
               cts_sync <= 2'b11; // RL8
            end else begin
               sin_sync <= {sin_sync[0], serial_in_pin[p]}; // RL8
               cts_sync <= {cts_sync[0], peer_n_pin[p]}; // RL8
            end
         end
         // Low on the pin means the far end is ready
         assign peer_ok = ~cts_sync[1]; // RL2
         assign peer_ready[p] = peer_ok; // RL3
         assign rx_level[p] = loopback[p] ? txd : sin_sync[1];

         always @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               rts_n <= `UMPC_READY_OFF_N; // RL5
            end else if (loopback[p]) begin
               rts_n <= `UMPC_READY_OFF_N; // RL6
            end else begin
               rts_n <= ~rts_request[p]; // RL4
            end
         end
         assign local_ready_n[p] = rts_n;

         umpc_fifo #(
            .WIDTH(`UMPC_DATA_BITS),
            .DEPTH(`UMPC_FIFO_DEPTH),
            .AW(4)
         ) tx_fifo (
            .ref_clk(ref_clk),
            .rst(rst),
            .in_valid(tx_valid[p]),
            .in_ready(tx_ready[p]),
            .in_data(tx_data[p*8 +: 8]),
            .out_valid(f_valid),
            .out_ready(f_ready),
            .out_data(f_data)
         );

         // Flow control stalls the FIFO so it really fills
         assign f_ready = !busy && (!cts_flow[p] || peer_ok || loopback[p]);

         always @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               baud_cnt <= 16'h0000;
               baud_tick <= 1'b0;
            end else if (!busy) begin
               // Preload one so the start bit stands a full bit time; divider must be 2 or more
               baud_cnt <= 16'h0001;
               baud_tick <= 1'b0;
            end else if (baud_cnt == baud_div[p*16 +: 16] - 16'h0001) begin
               baud_cnt <= 16'h0000;
               baud_tick <= 1'b1;
            end else begin
               baud_cnt <= baud_cnt + 16'h0001;
               baud_tick <= 1'b0;
            end
         end

         always @(posedge ref_clk or posedge rst) begin
            if (rst) begin
               txd <= `UMPC_LINE_MARK; // RL1
               busy <= 1'b0;
               bit_cnt <= 4'h0;
               shifter <= 9'h1FF;
            end else if (!busy) begin
               txd <= `UMPC_LINE_MARK; // RL1
               if (f_valid && f_ready) begin
                  busy <= 1'b1;
                  txd <= 1'b0;
                  shifter <= {1'b1, f_data};
                  bit_cnt <= 4'h9;
               end
            end else if (baud_tick) begin
               if (bit_cnt == 4'h0) begin
                  busy <= 1'b0;
                  txd <= `UMPC_LINE_MARK;
               end else begin
                  txd <= shifter[0];
                  shifter <= {1'b1, shifter[8:1]};
                  bit_cnt <= bit_cnt - 4'h1;
               end
            end
         end
         // Loopback keeps the line marking towards the far end
         assign serial_out[p] = loopback[p] ? `UMPC_LINE_MARK : txd;
      end
   endgenerate
endmodule
`default_nettype wire

// *** tb/umpc_top_sva.sv ***
// Pin handshake assertions: reset and request-to-send on both serial ports, the rest on the fast port only
`default_nettype none
module umpc_top_sva (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic fast_port_serial_in,
   input wire logic fast_port_serial_out,
   input wire logic fast_port_peer_ready_n,
   input wire logic fast_port_local_ready_n,
   input wire logic fast_rts_request,
   input wire logic fast_loopback,
   input wire logic fast_peer_ready,
   input wire logic fast_rx_level,
   input wire logic console_port_serial_out,
   input wire logic console_port_local_ready_n,
   input wire logic console_rts_request,
   input wire logic console_loopback
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence s_loop_held;
      fast_loopback ##1 fast_loopback;
   endsequence
   a_reset_line: assert property ($past(rst) |-> fast_port_serial_out && console_port_serial_out) else $error("line");
   a_reset_rts: assert property ($past(rst) |-> fast_port_local_ready_n && console_port_local_ready_n) else $error("rts");
   a_rts_on: assert property (fast_rts_request && !fast_loopback |=> !fast_port_local_ready_n) else $error("rts on");
   a_rts_off: assert property (!fast_rts_request |=> fast_port_local_ready_n) else $error("rts off");
   a_loop_rts: assert property (s_loop_held |-> fast_port_local_ready_n) else $error("loop rts");
   a_peer_sync: assert property (!$past(rst) && !$past(rst, 2) |-> fast_peer_ready == !$past(fast_port_peer_ready_n, 2))
      else $error("peer sync");
   a_rx_sync: assert property (!$past(rst, 2) && !fast_loopback && !$past(fast_loopback)
      |-> fast_rx_level == $past(fast_port_serial_in, 2)) else $error("rx sync");
   a_console_rts: assert property (console_rts_request && !console_loopback |=> !console_port_local_ready_n)
      else $error("console rts");
endmodule
bind umpc_top umpc_top_sva u_sva (.ref_clk, .rst, .fast_port_serial_in, .fast_port_serial_out, .fast_port_peer_ready_n,
   .fast_port_local_ready_n, .fast_rts_request, .fast_loopback, .fast_peer_ready, .fast_rx_level,
   .console_port_serial_out, .console_port_local_ready_n, .console_rts_request, .console_loopback);
`default_nettype wire

// *** tb/umpc_modem.sv ***
// Behavioural modem on the far side of one port
`default_nettype none
module umpc_modem (
   input wire logic ref_clk,
   input wire logic ready,
   input wire logic line,
   output var logic peer_ready_n,
   output wire logic serial_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial peer_ready_n = 1'b1;
   always @(posedge ref_clk) peer_ready_n <= !ready;
   // Line passes straight through with no pull-up; the bench idles it high
   assign serial_in = line;
endmodule
`default_nettype wire

// *** tb/tb_uart_modem_pin_control.sv ***
// Self-checking bench for the two-port pin control block
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
   $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module tb_uart_modem_pin_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 0, rst = 1;
   logic [1:0] vld = 0, req = 0, loop = 0, flow = 0, rdy_m = 0, line = 2'h3;
   logic [7:0] data = 0;
   wire logic [1:0] sin, sout, pr_n, rts_n, tx_rdy, prdy, rxl;
   int n_errors = 0, samples_checked = 0;
   umpc_modem m0 (.ref_clk, .ready(rdy_m[0]), .line(line[0]), .peer_ready_n(pr_n[0]), .serial_in(sin[0]));
   umpc_modem m1 (.ref_clk, .ready(rdy_m[1]), .line(line[1]), .peer_ready_n(pr_n[1]), .serial_in(sin[1]));
   // Short bit time of four cycles keeps frames 40 cycles long
   umpc_top #(.BAUD_DIV_FAST(16'h0004), .BAUD_DIV_CONSOLE(16'h0004)) dut (.ref_clk, .rst,
      .fast_port_serial_in(sin[0]), .fast_port_serial_out(sout[0]), .fast_port_peer_ready_n(pr_n[0]),
      .fast_port_local_ready_n(rts_n[0]), .fast_tx_valid(vld[0]), .fast_tx_ready(tx_rdy[0]), .fast_tx_data(data),
      .fast_rts_request(req[0]), .fast_loopback(loop[0]), .fast_cts_flow(flow[0]), .fast_peer_ready(prdy[0]),
      .fast_rx_level(rxl[0]), .console_port_serial_in(sin[1]), .console_port_serial_out(sout[1]),
      .console_port_peer_ready_n(pr_n[1]), .console_port_local_ready_n(rts_n[1]), .console_tx_valid(vld[1]),
      .console_tx_ready(tx_rdy[1]), .console_tx_data(data), .console_rts_request(req[1]),
      .console_loopback(loop[1]), .console_cts_flow(flow[1]), .console_peer_ready(prdy[1]), .console_rx_level(rxl[1]));
   task automatic cyc(int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic t_reset;
      #1 `CHK({sout, rts_n, tx_rdy, prdy, rxl}, 10'h3F3)
      $display("reset done");
   endtask
   task automatic t_rts;
      cyc(1); req <= 2'h1; cyc(2);
      #1 `CHK(rts_n, 2'h2)
      cyc(1); req <= 2'h3; loop <= 2'h3; cyc(2);
      #1 `CHK(rts_n, 2'h3)
      cyc(1); req <= 2'h0; loop <= 2'h0; cyc(2);
      #1 `CHK(rts_n, 2'h3)
      $display("rts done");
   endtask
   task automatic t_peer;
      cyc(1); rdy_m <= 2'h1; line <= 2'h2; loop <= 2'h2; cyc(5);
      #1 `CHK({prdy, rxl}, 4'h6)
      cyc(1); rdy_m <= 2'h0; line <= 2'h3; loop <= 2'h0;
      $display("peer done");
   endtask
   task automatic t_frame;
      int n;
      logic [9:0] fr;
      fr = {1'b1, 8'hA5, 1'b0};
      n = 0;
      cyc(1); data <= 8'hA5; vld <= 2'h1;
      cyc(1); vld <= 2'h0;
      #1 while (sout[0] !== 1'b0 && n < 20) begin cyc(1); #1 n++; end
      if (n == 20) begin n_errors++; final_report; end
      cyc(2);
      for (int i = 0; i < 10; i++) begin #1 `CHK(sout, {1'b1, fr[i]}) cyc(4); end
      $display("frame done");
   endtask
   task automatic t_fifo;
      int k;
      k = 0;
      // Peer not ready with flow on, so nothing drains while filling
      cyc(1); flow <= 2'h3; vld <= 2'h3;
      repeat (20) begin #1 k += tx_rdy[0]; cyc(1); end
      vld <= 2'h0;
      #1 `CHK({k[7:0], tx_rdy, sout}, 12'h103)
      cyc(1); rdy_m <= 2'h3; cyc(800);
      #1 `CHK({tx_rdy, sout}, 4'hF)
      cyc(1); flow <= 2'h0;
      $display("fifo done");
   endtask
   initial forever #2.5 ref_clk = ~ref_clk;
   initial begin
      cyc(12); rst <= 1'b0;
      t_reset;
      t_rts;
      t_peer;
      t_frame;
      t_fifo;
      final_report;
   end
endmodule
`default_nettype wire
